// file: core/scc_ctrl.sv
`timescale 1ns/10ps
// Functional notes
// [RULE_01] Position pair encodes state 0..3.
// [RULE_02] Event on every state code change.
// [RULE_03] Origin mode input must be active.
// [RULE_04] Matching permit needed for open/close.
// [RULE_05] Breaker close also needs sync ok.
// [RULE_06] Local and remote enabled separately.
// [RULE_07] Block input refuses all commands.
// [RULE_08] Three control models, direct normal default.
// [RULE_09] Forced check overrides command skip attribute.
// [RULE_10] Enhanced: no move in time, error.
// [RULE_11] Command pulse lasts the set duration.
// [RULE_12] Confirmed move ends pulse, not before minimum.
// [RULE_13] Intermediate reported only after filter time.
// [RULE_14] Selection expires, late operate does nothing.
// [RULE_15] Both sources checked, forwarded, status reported.
// [RULE_16] Operation pulse of 150 ms.
// [RULE_17] Operation counter, externally clearable.
// [RULE_18] Timers count shared tick, restart on start.
// [RULE_19] Colliding or busy requests are rejected.
module scc_ctrl #(
   parameter int TICK_CYC = scc_pkg::TICK_CYC
) (
   input wire logic sys_clk_i, // System clock, 20 MHz.
   input wire logic arst_n_i, // Asynchronous reset, active low.
   input wire logic [scc_pkg::AW-1:0] reg_addr_i, // Register byte address.
   input wire logic [31:0] reg_wdata_i, // Register write data.
   input wire logic reg_wr_i, // Write strobe.
   input wire logic reg_rd_i, // Read strobe.
   output logic [31:0] reg_rdata_o, // Read data, cycle after strobe.
   input wire logic closed_position_in_i, // Closed contact pin.
   input wire logic open_position_in_i, // Open contact pin.
   input wire logic local_mode_i, // Local operation allowed pin.
   input wire logic remote_mode_i, // Remote operation allowed pin.
   input wire logic open_permit_i, // Open interlock permit pin.
   input wire logic close_permit_i, // Close interlock permit pin.
   input wire logic sync_check_ok_i, // Synchro check pin.
   input wire logic block_i, // Blocking pin.
   input wire scc_pkg::scc_cmd_t loc_cmd_i, // Local panel request.
   input wire scc_pkg::scc_cmd_t rem_cmd_i, // Remote station request.
   input wire logic cnt_clr_i, // Clears the operation counter.
   output scc_pkg::scc_resp_t loc_resp_o, // Answer to local source.
   output scc_pkg::scc_resp_t rem_resp_o, // Answer to remote source.
   output logic cmd_open_o, // Open command pulse.
   output logic cmd_close_o, // Close command pulse.
   output logic oper_o, // Operation pulse.
   output logic state_evt_o, // State change event pulse.
   output logic [1:0] switch_state_code_o, // Filtered state code.
   output logic opened_o, // Filtered open state.
   output logic closed_o, // Filtered closed state.
   output logic irq_o // Interrupt, active high level.
);
   localparam int DIV_W = $clog2(TICK_CYC);

   logic [7:0] pin_s1_ff;
   logic [7:0] pin_s2_ff;
   logic [DIV_W-1:0] div_ff;
   logic tick_ff;
   logic [scc_pkg::CTRL_W-1:0] ctrl_ff;
   logic [scc_pkg::MS_W-1:0] pulse_ff;
   logic [scc_pkg::MS_W-1:0] maxop_ff;
   logic [scc_pkg::MS_W-1:0] maxint_ff;
   logic [scc_pkg::MS_W-1:0] sbo_ff;
   logic [scc_pkg::IRQ_W-1:0] irq_stat_ff;
   logic [scc_pkg::IRQ_W-1:0] irq_mask_ff;
   logic [31:0] op_cnt_ff;
   logic [1:0] rep_ff;
   logic [1:0] nxt_rep;
   logic cmd_open_ff;
   logic cmd_close_ff;
   logic op_wait_ff;
   logic op_close_ff;
   logic op_rem_ff;
   logic oper_ff;
   logic evt_ff;
   logic sel_rem_ff;
   logic sel_close_ff;
   scc_pkg::scc_st_t st_ff;
   scc_pkg::scc_resp_t loc_resp_ff;
   scc_pkg::scc_resp_t rem_resp_ff;
   scc_pkg::scc_cmd_t c;
   logic c_rem;
   logic one;
   logic ok;
   logic busy;
   logic sbo_exp;
   logic issue;
   logic select;
   logic pulse_end;
   logic op_done;
   logic op_err;
   logic oper_start;
   logic [1:0] raw_code;
   logic [scc_pkg::MS_W-1:0] int_cnt;
   logic [scc_pkg::MS_W-1:0] pulse_cnt;
   logic [scc_pkg::MS_W-1:0] op_cnt;
   logic [scc_pkg::MS_W-1:0] sel_cnt;
   logic [scc_pkg::MS_W-1:0] oper_cnt;
   logic [scc_pkg::IRQ_W-1:0] ev;
   logic wr_ctrl;
   logic [1:0] model;

   wire closed_s = pin_s2_ff[7];
   wire open_s = pin_s2_ff[6];
   wire loc_s = pin_s2_ff[5];
   wire rem_s = pin_s2_ff[4];
   wire open_perm_s = pin_s2_ff[3];
   wire close_perm_s = pin_s2_ff[2];
   wire sync_s = pin_s2_ff[1];
   wire blk_s = pin_s2_ff[0];

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pin_s1_ff <= '0;
         pin_s2_ff <= '0;
      end else begin
         pin_s1_ff <= {closed_position_in_i, open_position_in_i, local_mode_i, remote_mode_i,
                       open_permit_i, close_permit_i, sync_check_ok_i, block_i};
         pin_s2_ff <= pin_s1_ff;
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         div_ff <= '0;
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= (div_ff == DIV_W'(TICK_CYC - 1)); // see [RULE_18]
         div_ff <= (div_ff == DIV_W'(TICK_CYC - 1)) ? '0 : div_ff + 1'b1;
      end
   end

   scc_ms_timer #(.W(scc_pkg::MS_W)) u_int_tmr (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .tick_i(tick_ff),
      .run_i(raw_code == scc_pkg::POS_INT), .cnt_o(int_cnt));
   scc_ms_timer #(.W(scc_pkg::MS_W)) u_pulse_tmr (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .tick_i(tick_ff),
      .run_i(busy), .cnt_o(pulse_cnt));
   scc_ms_timer #(.W(scc_pkg::MS_W)) u_op_tmr (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .tick_i(tick_ff),
      .run_i(op_wait_ff), .cnt_o(op_cnt));
   scc_ms_timer #(.W(scc_pkg::MS_W)) u_sel_tmr (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .tick_i(tick_ff),
      .run_i(st_ff == scc_pkg::ST_SEL), .cnt_o(sel_cnt));
   scc_ms_timer #(.W(scc_pkg::MS_W)) u_oper_tmr (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .tick_i(tick_ff),
      .run_i(oper_ff), .cnt_o(oper_cnt));

   function automatic logic [scc_pkg::MS_W-1:0] clamp(input logic [31:0] v, input logic [scc_pkg::MS_W-1:0] lo,
                                                      input logic [scc_pkg::MS_W-1:0] hi);
      if (v < {16'h0000, lo}) begin
         return lo;
      end
      if (v > {16'h0000, hi}) begin
         return hi;
      end
      return v[scc_pkg::MS_W-1:0];
   endfunction : clamp

   function automatic logic cmd_ok(input scc_pkg::scc_cmd_t r, input logic remote);
      logic origin;
      logic perm;
      origin = remote ? (rem_s & ctrl_ff[scc_pkg::CTRL_REM]) : (loc_s & ctrl_ff[scc_pkg::CTRL_LOC]); // see [RULE_03] see [RULE_06]
      perm = r.close ? (close_perm_s & (sync_s | !ctrl_ff[scc_pkg::CTRL_BRK])) : open_perm_s; // see [RULE_04] see [RULE_05]
      return origin & !blk_s & (perm | (r.skip & !ctrl_ff[scc_pkg::CTRL_FORCE])); // see [RULE_07] see [RULE_09]
   endfunction : cmd_ok

   assign raw_code = {closed_s, open_s}; // see [RULE_01]
   assign model = ctrl_ff[1:0];
   assign wr_ctrl = reg_wr_i && reg_addr_i == scc_pkg::REG_CTRL;

   // Intermediate is held off until it has lasted the filter time.
   always_comb begin
      nxt_rep = rep_ff;
      if (raw_code != scc_pkg::POS_INT) begin
         nxt_rep = raw_code;
      end else if (int_cnt >= maxint_ff) begin // see [RULE_13]
         nxt_rep = scc_pkg::POS_INT;
      end
   end

   always_comb begin
      c = loc_cmd_i.valid ? loc_cmd_i : rem_cmd_i;
      c_rem = !loc_cmd_i.valid;
      one = loc_cmd_i.valid ^ rem_cmd_i.valid; // see [RULE_19]
      ok = cmd_ok(c, c_rem); // see [RULE_15]
      busy = cmd_open_ff | cmd_close_ff;
      sbo_exp = st_ff == scc_pkg::ST_SEL && sel_cnt >= sbo_ff; // see [RULE_14]
      issue = 1'b0;
      select = 1'b0;
      if (one && !busy && !sbo_exp) begin // see [RULE_19]
         if (model == scc_pkg::MDL_SBO) begin // see [RULE_08]
            if (st_ff == scc_pkg::ST_IDLE) begin
               select = c.sel & ok;
            end else begin
               issue = !c.sel & ok & (c_rem == sel_rem_ff) & (c.close == sel_close_ff);
            end
         end else begin
            issue = !c.sel & ok;
         end
      end
   end

   assign op_done = raw_code == (op_close_ff ? scc_pkg::POS_ON : scc_pkg::POS_OFF);
   assign op_err = op_wait_ff && !op_done && op_cnt >= maxop_ff; // see [RULE_10]
   assign pulse_end = busy && (pulse_cnt >= pulse_ff || (pulse_cnt >= scc_pkg::MIN_PULSE_MS && raw_code ==
                      (cmd_close_ff ? scc_pkg::POS_ON : scc_pkg::POS_OFF))); // see [RULE_11] see [RULE_12]
   assign oper_start = evt_ff && !oper_ff && (rep_ff == scc_pkg::POS_ON || rep_ff == scc_pkg::POS_OFF);

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rep_ff <= scc_pkg::POS_INT;
         evt_ff <= 1'b0;
      end else begin
         rep_ff <= nxt_rep;
         evt_ff <= nxt_rep != rep_ff; // see [RULE_02]
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st_ff <= scc_pkg::ST_IDLE;
         sel_rem_ff <= 1'b0;
         sel_close_ff <= 1'b0;
      end else if (sbo_exp || issue) begin
         st_ff <= scc_pkg::ST_IDLE; // see [RULE_14]
      end else if (select) begin
         st_ff <= scc_pkg::ST_SEL;
         sel_rem_ff <= c_rem;
         sel_close_ff <= c.close;
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cmd_open_ff <= 1'b0;
         cmd_close_ff <= 1'b0;
      end else if (issue) begin
         cmd_open_ff <= !c.close; // see [RULE_11]
         cmd_close_ff <= c.close;
      end else if (pulse_end) begin
         cmd_open_ff <= 1'b0;
         cmd_close_ff <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         op_wait_ff <= 1'b0;
         op_close_ff <= 1'b0;
         op_rem_ff <= 1'b0;
      end else if (issue) begin
         op_wait_ff <= model != scc_pkg::MDL_DN; // see [RULE_10]
         op_close_ff <= c.close;
         op_rem_ff <= c_rem;
      end else if (op_done || op_err) begin
         op_wait_ff <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         loc_resp_ff <= '0;
         rem_resp_ff <= '0;
      end else begin
         loc_resp_ff.ack <= issue & !c_rem;
         loc_resp_ff.sel_ok <= select & !c_rem;
         loc_resp_ff.nak <= loc_cmd_i.valid & !((issue | select) & !c_rem); // see [RULE_19]
         loc_resp_ff.pos_err <= op_err & !op_rem_ff;
         rem_resp_ff.ack <= issue & c_rem;
         rem_resp_ff.sel_ok <= select & c_rem;
         rem_resp_ff.nak <= rem_cmd_i.valid & !((issue | select) & c_rem);
         rem_resp_ff.pos_err <= op_err & op_rem_ff;
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         oper_ff <= 1'b0;
         op_cnt_ff <= '0;
      end else begin
         if (oper_start) begin
            oper_ff <= 1'b1;
         end else if (oper_cnt >= scc_pkg::OPER_MS) begin // see [RULE_16]
            oper_ff <= 1'b0;
         end
         if (cnt_clr_i) begin
            op_cnt_ff <= '0;
         end else if (oper_start) begin
            op_cnt_ff <= op_cnt_ff + 1'b1; // see [RULE_17]
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ctrl_ff <= scc_pkg::CTRL_RST;
         pulse_ff <= scc_pkg::PULSE_DEF;
         maxop_ff <= scc_pkg::MAXOP_DEF;
         maxint_ff <= scc_pkg::MAXINT_DEF;
         sbo_ff <= scc_pkg::SBO_DEF;
         irq_mask_ff <= '0;
      end else if (reg_wr_i) begin
         if (wr_ctrl && reg_wdata_i[1:0] != 2'h3) begin
            ctrl_ff <= reg_wdata_i[scc_pkg::CTRL_W-1:0]; // see [RULE_08]
         end
         if (reg_addr_i == scc_pkg::REG_PULSE) begin
            pulse_ff <= clamp(reg_wdata_i, scc_pkg::PULSE_LO, scc_pkg::SET_HI);
         end
         if (reg_addr_i == scc_pkg::REG_MAXOP) begin
            maxop_ff <= clamp(reg_wdata_i, scc_pkg::MAXOP_LO, scc_pkg::SET_HI);
         end
         if (reg_addr_i == scc_pkg::REG_MAXINT) begin
            maxint_ff <= clamp(reg_wdata_i, scc_pkg::MAXINT_LO, scc_pkg::SET_HI);
         end
         if (reg_addr_i == scc_pkg::REG_SBO) begin
            sbo_ff <= clamp(reg_wdata_i, scc_pkg::SBO_LO, scc_pkg::SBO_HI);
         end
         if (reg_addr_i == scc_pkg::REG_IRQ_MASK) begin
            irq_mask_ff <= reg_wdata_i[scc_pkg::IRQ_W-1:0];
         end
      end
   end

   // A new event in the clearing cycle survives the write-one-to-clear.
   assign ev = {op_err, sbo_exp, loc_resp_ff.nak | rem_resp_ff.nak, oper_start, evt_ff};
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         irq_stat_ff <= '0;
      end else if (reg_wr_i && reg_addr_i == scc_pkg::REG_IRQ_STAT) begin
         irq_stat_ff <= (irq_stat_ff & ~reg_wdata_i[scc_pkg::IRQ_W-1:0]) | ev;
      end else begin
         irq_stat_ff <= irq_stat_ff | ev;
      end
   end

   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         reg_rdata_o <= '0;
      end else if (!reg_rd_i) begin
         reg_rdata_o <= '0;
      end else begin
         case (reg_addr_i)
            scc_pkg::REG_CTRL: reg_rdata_o <= {26'h0, ctrl_ff};
            scc_pkg::REG_PULSE: reg_rdata_o <= {16'h0, pulse_ff};
            scc_pkg::REG_MAXOP: reg_rdata_o <= {16'h0, maxop_ff};
            scc_pkg::REG_MAXINT: reg_rdata_o <= {16'h0, maxint_ff};
            scc_pkg::REG_SBO: reg_rdata_o <= {16'h0, sbo_ff};
            scc_pkg::REG_STATUS: reg_rdata_o <= {22'h0, oper_ff, op_wait_ff, st_ff == scc_pkg::ST_SEL,
                                                  cmd_close_ff, cmd_open_ff, blk_s, raw_code, rep_ff};
            scc_pkg::REG_IRQ_STAT: reg_rdata_o <= {27'h0, irq_stat_ff};
            scc_pkg::REG_IRQ_MASK: reg_rdata_o <= {27'h0, irq_mask_ff};
            scc_pkg::REG_OPCNT: reg_rdata_o <= op_cnt_ff;
            default: reg_rdata_o <= '0;
         endcase
      end
   end

   assign loc_resp_o = loc_resp_ff;
   assign rem_resp_o = rem_resp_ff;
   assign cmd_open_o = cmd_open_ff;
   assign cmd_close_o = cmd_close_ff;
   assign oper_o = oper_ff;
   assign state_evt_o = evt_ff;
   assign switch_state_code_o = rep_ff;
   assign opened_o = rep_ff == scc_pkg::POS_OFF;
   assign closed_o = rep_ff == scc_pkg::POS_ON;
   assign irq_o = |(irq_stat_ff & irq_mask_ff);

   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!arst_n_i);

   property p_code_follow;
      raw_code != scc_pkg::POS_INT |=> switch_state_code_o == $past(raw_code);
   endproperty
   a_code_follow: assert property (p_code_follow) else $error("State code not following contacts."); // see [RULE_01]
   property p_evt;
      switch_state_code_o != $past(switch_state_code_o) |-> state_evt_o;
   endproperty
   a_evt: assert property (p_evt) else $error("State change without event."); // see [RULE_02]
   property p_gate;
      issue |-> !blk_s && (c_rem ? rem_s && ctrl_ff[scc_pkg::CTRL_REM] : loc_s && ctrl_ff[scc_pkg::CTRL_LOC]);
   endproperty
   a_gate: assert property (p_gate) else $error("Command issued without mode or while blocked."); // see [RULE_07]
   property p_perm;
      issue && !(c.skip && !ctrl_ff[scc_pkg::CTRL_FORCE]) |->
         (c.close ? close_perm_s && (sync_s || !ctrl_ff[scc_pkg::CTRL_BRK]) : open_perm_s);
   endproperty
   a_perm: assert property (p_perm) else $error("Command issued without permit."); // see [RULE_04]
   property p_excl;
      !(cmd_open_o && cmd_close_o) && !((cmd_open_o || cmd_close_o) && $rose(cmd_open_o || cmd_close_o) &&
      $past(loc_cmd_i.valid && rem_cmd_i.valid));
   endproperty
   a_excl: assert property (p_excl) else $error("Both outputs or colliding requests executed."); // see [RULE_19]
   property p_pulse_len;
      $fell(cmd_open_o || cmd_close_o) |-> $past(pulse_cnt) >= (pulse_ff < scc_pkg::MIN_PULSE_MS ?
         pulse_ff : scc_pkg::MIN_PULSE_MS) && $past(pulse_cnt) <= pulse_ff;
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("Command pulse length wrong."); // see [RULE_12]
   property p_sbo;
      st_ff == scc_pkg::ST_SEL && sel_cnt >= sbo_ff |=> st_ff == scc_pkg::ST_IDLE && !cmd_open_o && !cmd_close_o;
   endproperty
   a_sbo: assert property (p_sbo) else $error("Expired selection still acted."); // see [RULE_14]
   property p_poserr;
      op_err |=> (op_rem_ff ? rem_resp_o.pos_err : loc_resp_o.pos_err) && !op_wait_ff;
   endproperty
   a_poserr: assert property (p_poserr) else $error("Operate timeout not reported."); // see [RULE_10]
   property p_oper;
      oper_o |-> oper_cnt <= scc_pkg::OPER_MS;
   endproperty
   a_oper: assert property (p_oper) else $error("Operation pulse too long."); // see [RULE_16]
   property p_count;
      $rose(oper_o) && !$past(cnt_clr_i) |-> op_cnt_ff == $past(op_cnt_ff) + 32'h1;
   endproperty
   a_count: assert property (p_count) else $error("Operation counter missed an operation."); // see [RULE_17]
   property p_direct;
      model != scc_pkg::MDL_SBO && c.sel |-> !issue && !select;
   endproperty
   a_direct: assert property (p_direct) else $error("Selection accepted in a direct model."); // see [RULE_08]

   c_close: cover property ($rose(cmd_close_o));
   c_open: cover property ($rose(cmd_open_o));
   c_sbo_exp: cover property (sbo_exp);
   c_poserr: cover property (op_err);
endmodule : scc_ctrl

// file: core/scc_pkg.sv
package scc_pkg;
   // Time base: one millisecond tick derived from the system clock.
   localparam int CLK_HZ = 20_000_000;
   localparam int TICK_US = 1000;
   localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
   localparam int MS_W = 16;
   localparam int AW = 6;
   // Register byte offsets.
   localparam logic [AW-1:0] REG_CTRL = 6'h00;
   localparam logic [AW-1:0] REG_PULSE = 6'h04;
   localparam logic [AW-1:0] REG_MAXOP = 6'h08;
   localparam logic [AW-1:0] REG_MAXINT = 6'h0c;
   localparam logic [AW-1:0] REG_SBO = 6'h10;
   localparam logic [AW-1:0] REG_STATUS = 6'h14;
   localparam logic [AW-1:0] REG_IRQ_STAT = 6'h18;
   localparam logic [AW-1:0] REG_IRQ_MASK = 6'h1c;
   localparam logic [AW-1:0] REG_OPCNT = 6'h20;
   // Control register fields.
   localparam int CTRL_W = 6;
   localparam int CTRL_FORCE = 2;
   localparam int CTRL_BRK = 3;
   localparam int CTRL_LOC = 4;
   localparam int CTRL_REM = 5;
   localparam logic [CTRL_W-1:0] CTRL_RST = 6'h3c;
   // Millisecond settings: default, lowest and highest value.
   localparam logic [MS_W-1:0] PULSE_DEF = 16'h03e8;
   localparam logic [MS_W-1:0] PULSE_LO = 16'h0064;
   localparam logic [MS_W-1:0] MAXOP_DEF = 16'h2710;
   localparam logic [MS_W-1:0] MAXOP_LO = 16'h000a;
   localparam logic [MS_W-1:0] MAXINT_DEF = 16'h2710;
   localparam logic [MS_W-1:0] MAXINT_LO = 16'h0014;
   localparam logic [MS_W-1:0] SBO_DEF = 16'h1388;
   localparam logic [MS_W-1:0] SBO_LO = 16'h03e8;
   localparam logic [MS_W-1:0] SBO_HI = 16'h4e20;
   localparam logic [MS_W-1:0] SET_HI = 16'hea60;
   localparam logic [MS_W-1:0] MIN_PULSE_MS = 16'h03e8;
   localparam logic [MS_W-1:0] OPER_MS = 16'h0096;
   // Interrupt status bits.
   localparam int IRQ_W = 5;
   localparam int IRQ_STATE = 0;
   localparam int IRQ_OPER = 1;
   localparam int IRQ_NAK = 2;
   localparam int IRQ_SBO = 3;
   localparam int IRQ_POSERR = 4;

   typedef enum logic [1:0] {
      POS_INT = 2'h0,
      POS_OFF = 2'h1,
      POS_ON = 2'h2,
      POS_BAD = 2'h3
   } scc_pos_t;

   typedef enum logic [1:0] {
      MDL_DN = 2'h0,
      MDL_DE = 2'h1,
      MDL_SBO = 2'h2
   } scc_model_t;

   typedef enum {
      ST_IDLE,
      ST_SEL
   } scc_st_t;

   typedef struct packed {
      logic valid;
      logic close;
      logic sel;
      logic skip;
   } scc_cmd_t;

   typedef struct packed {
      logic ack;
      logic nak;
      logic sel_ok;
      logic pos_err;
   } scc_resp_t;
endpackage : scc_pkg

// file: core/scc_ms_timer.sv
`timescale 1ns/10ps
module scc_ms_timer #(
   parameter int W = 16
) (
   input wire logic sys_clk_i, // System clock.
   input wire logic arst_n_i, // Asynchronous reset, active low.
   input wire logic tick_i, // One millisecond enable pulse.
   input wire logic run_i, // Counts while high, clears while low.
   output logic [W-1:0] cnt_o // Whole ticks since run rose.
);
   always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         cnt_o <= '0;
      end else if (!run_i) begin
         cnt_o <= '0;
      end else if (tick_i && cnt_o != '1) begin
         cnt_o <= cnt_o + 1'b1;
      end
   end
endmodule : scc_ms_timer

// file: dv/scc_sw_model.sv
`timescale 1ns/10ps
// Contacts of the switchgear: they leave the old end position, pass through
// intermediate, then reach the commanded end position, unless stuck.
module scc_sw_model #(
   parameter int DLY = 100
) (
   input wire logic sys_clk_i, // System clock.
   input wire logic cmd_open_i, // Open command pulse.
   input wire logic cmd_close_i, // Close command pulse.
   input wire logic stuck_i, // Mechanism jammed.
   output logic closed_o = 1'b0, // Closed contact.
   output logic open_o = 1'b1 // Open contact.
);
   int cnt_ff = 0;
   logic tgt_ff = 1'b0;
   always_ff @(posedge sys_clk_i) begin
      if (cmd_open_i | cmd_close_i) begin
         tgt_ff <= cmd_close_i;
         cnt_ff <= cnt_ff + 1;
      end else begin
         cnt_ff <= 0;
      end
      if (!stuck_i && cnt_ff == DLY / 2) begin
         closed_o <= 1'b0;
         open_o <= 1'b0;
      end
      if (!stuck_i && cnt_ff == DLY) begin
         closed_o <= tgt_ff;
         open_o <= !tgt_ff;
      end
   end
endmodule : scc_sw_model

// file: dv/tb.sv
`timescale 1ns/10ps
module tb;
   logic sys_clk_i, arst_n_i = 0, reg_wr_i = 0, reg_rd_i = 0, cnt_clr_i = 0, stuck = 0;
   logic local_mode_i = 1, remote_mode_i = 1, open_permit_i = 1, close_permit_i = 1;
   logic sync_check_ok_i = 0, block_i = 0, closed_position_in_i, open_position_in_i;
   logic [5:0] reg_addr_i = '0;
   logic [31:0] reg_wdata_i = '0, reg_rdata_o;
   scc_pkg::scc_cmd_t loc_cmd_i = '0, rem_cmd_i = '0;
   scc_pkg::scc_resp_t loc_resp_o, rem_resp_o, s;
   logic cmd_open_o, cmd_close_o, oper_o, state_evt_o, opened_o, closed_o, irq_o;
   logic [1:0] switch_state_code_o;
   int fails = 0, tests_run = 0, n;
   scc_ctrl #(.TICK_CYC(20)) u_scc_ctrl (.sys_clk_i, .arst_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
      .reg_rd_i, .reg_rdata_o, .closed_position_in_i, .open_position_in_i, .local_mode_i, .remote_mode_i,
      .open_permit_i, .close_permit_i, .sync_check_ok_i, .block_i, .loc_cmd_i, .rem_cmd_i, .cnt_clr_i,
      .loc_resp_o, .rem_resp_o, .cmd_open_o, .cmd_close_o, .oper_o, .state_evt_o, .switch_state_code_o,
      .opened_o, .closed_o, .irq_o);
   scc_sw_model u_scc_sw_model (.sys_clk_i, .cmd_open_i(cmd_open_o), .cmd_close_i(cmd_close_o),
      .stuck_i(stuck), .closed_o(closed_position_in_i), .open_o(open_position_in_i));
   initial begin
      sys_clk_i = 0;
      forever #25 sys_clk_i = ~sys_clk_i;
   end
   task complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : complete_run
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task clk1;
      @(posedge sys_clk_i);
      #1;
   endtask : clk1
   task wr_r(input logic [5:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1;
      @(posedge sys_clk_i);
      reg_wr_i <= 0;
   endtask : wr_r
   task rd_r(input logic [5:0] a, input logic [31:0] e);
      @(posedge sys_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1;
      @(posedge sys_clk_i);
      reg_rd_i <= 0;
      #1 chk(reg_rdata_o, e);
   endtask : rd_r
   // Request word is {valid, close, sel, skip}; the answer stands one cycle later.
   task send(input logic rem, input logic [3:0] c);
      @(posedge sys_clk_i);
      if (rem) rem_cmd_i <= c;
      else loc_cmd_i <= c;
      @(posedge sys_clk_i);
      rem_cmd_i <= '0;
      loc_cmd_i <= '0;
      #1 s = rem ? rem_resp_o : loc_resp_o;
   endtask : send
   task pulse_len;
      n = 0;
      while ((cmd_close_o === 1'b1 || cmd_open_o === 1'b1) && n < 25000) begin
         clk1();
         n++;
      end
      if (n >= 25000) begin
         fails++;
         complete_run();
      end
   endtask : pulse_len
   initial begin
      repeat (4) @(posedge sys_clk_i);
      arst_n_i <= 1;
      rd_r(scc_pkg::REG_CTRL, 32'h3c);
      rd_r(scc_pkg::REG_PULSE, 32'h3e8);
      rd_r(scc_pkg::REG_MAXOP, 32'h2710);
      rd_r(scc_pkg::REG_MAXINT, 32'h2710);
      rd_r(scc_pkg::REG_SBO, 32'h1388);
      rd_r(6'h24, 32'h0);
      chk(switch_state_code_o, 2'h1);
      chk(opened_o, 1'b1);
      // Let the start-up operation pulse run out before counting.
      repeat (3200) @(posedge sys_clk_i);
      cnt_clr_i <= 1;
      wr_r(scc_pkg::REG_IRQ_STAT, 32'h1f);
      cnt_clr_i <= 0;
      wr_r(scc_pkg::REG_PULSE, 32'h32);
      rd_r(scc_pkg::REG_PULSE, 32'h64);
      wr_r(scc_pkg::REG_MAXOP, 32'ha);
      wr_r(scc_pkg::REG_CTRL, 32'h3d);
      wr_r(scc_pkg::REG_IRQ_MASK, 32'h1f);
      send(1, 4'hc);
      chk(s, 4'h4);
      // Pins pass two synchroniser stages, so each change is given time to arrive.
      sync_check_ok_i <= 1;
      block_i <= 1;
      repeat (2) @(posedge sys_clk_i);
      send(1, 4'hc);
      chk(s, 4'h4);
      block_i <= 0;
      remote_mode_i <= 0;
      repeat (2) @(posedge sys_clk_i);
      send(1, 4'hc);
      chk(s, 4'h4);
      remote_mode_i <= 1;
      close_permit_i <= 0;
      repeat (2) @(posedge sys_clk_i);
      send(1, 4'hd);
      chk(s, 4'h4);
      close_permit_i <= 1;
      repeat (3) @(posedge sys_clk_i);
      send(1, 4'hc);
      chk(s, 4'h8);
      chk(cmd_close_o, 1'b1);
      send(0, 4'h8);
      chk(s, 4'h4);
      pulse_len();
      chk(n >= 1975 && n <= 2025, 1'b1);
      chk(switch_state_code_o, 2'h2);
      chk(closed_o, 1'b1);
      rd_r(scc_pkg::REG_IRQ_STAT, 32'h7);
      chk(irq_o, 1'b1);
      wr_r(scc_pkg::REG_IRQ_MASK, 32'h0);
      clk1();
      chk(irq_o, 1'b0);
      wr_r(scc_pkg::REG_IRQ_STAT, 32'h7);
      wr_r(scc_pkg::REG_IRQ_MASK, 32'h1f);
      rd_r(scc_pkg::REG_IRQ_STAT, 32'h0);
      chk(irq_o, 1'b0);
      rd_r(scc_pkg::REG_OPCNT, 32'h1);
      chk(oper_o, 1'b1);
      repeat (1200) @(posedge sys_clk_i);
      #1 chk(oper_o, 1'b0);
      @(posedge sys_clk_i);
      cnt_clr_i <= 1;
      @(posedge sys_clk_i);
      cnt_clr_i <= 0;
      rd_r(scc_pkg::REG_OPCNT, 32'h0);
      stuck <= 1;
      send(0, 4'h8);
      chk(s, 4'h8);
      chk(cmd_open_o, 1'b1);
      n = 0;
      while (loc_resp_o.pos_err !== 1'b1 && n < 400) begin
         clk1();
         n++;
      end
      chk(n >= 180 && n <= 220, 1'b1);
      pulse_len();
      // Select-before-operate with a long pulse that the contacts cut short.
      stuck <= 0;
      wr_r(scc_pkg::REG_PULSE, 32'h5dc);
      wr_r(scc_pkg::REG_CTRL, 32'h3e);
      wr_r(scc_pkg::REG_SBO, 32'h0);
      rd_r(scc_pkg::REG_SBO, 32'h3e8);
      send(1, 4'h8);
      chk(s, 4'h4);
      send(1, 4'ha);
      chk(s, 4'h2);
      send(1, 4'h8);
      chk(s, 4'h8);
      pulse_len();
      chk(n >= 19950 && n <= 20050, 1'b1);
      chk(opened_o, 1'b1);
      send(1, 4'he);
      chk(s, 4'h2);
      repeat (20100) @(posedge sys_clk_i);
      send(1, 4'hc);
      chk(s, 4'h4);
      chk(cmd_close_o, 1'b0);
      complete_run();
   end
   initial begin
      #5000000;
      fails++;
      complete_run();
   end
endmodule : tb
